// ---- mcps_top.sv ----
// Pin sequencer, fault/retry timing and PWM stage of the motor controller
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mcps_top import mcps_pkg::*; #(
   parameter int PUMP_CYCLES = PUMP_CYCLES_DEF,
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // Reset pin drive
   input wire logic i_internal_reset_req,
   output logic o_reset_out,
   output logic o_reset_oe,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Digital control inputs
   input wire logic i_polarity_basefreq_select,
   input wire logic i_fault_input,
   input wire logic i_direction_input,
   input wire logic i_start_input,
   input wire logic i_bus_over_threshold,
   // Probe pins: mux, speed, ramp rate, bus sense
   output logic [3:0] o_probe_out,
   output logic [3:0] o_probe_oe,
   // Strobe and serial pins
   input wire logic i_pwm_rate_strobe_rx,
   output logic o_pwm_rate_strobe_rx,
   output logic o_pwm_rate_strobe_rx_oe,
   output logic o_retry_strobe_tx,
   output logic o_deadtime_strobe_fault_out,
   input wire logic i_boost_strobe_mode_select,
   output logic o_boost_strobe_mode_select,
   output logic o_boost_strobe_mode_select_oe,
   // Host serial user side
   input wire logic i_host_txd,
   output logic o_host_rxd,
   // Brake and PWM stage
   output logic o_brake_resistor_drive,
   output logic o_phase_u_high_drive,
   output logic o_phase_u_low_drive,
   output logic o_phase_v_high_drive,
   output logic o_phase_v_low_drive,
   output logic o_phase_w_high_drive,
   output logic o_phase_w_low_drive,
   output logic o_pwm_oe
);
   generate
      if (PUMP_CYCLES < 1 || PUMP_CYCLES >= 2**20 || TICK_CYCLES < 1 || TICK_CYCLES >= 2**20)
      begin : g_bad_param
         $error("mcps_top: count parameter out of range");
      end
   endgenerate

   mcps_state_t state;
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic standalone, pol_set, pol_hi, pol_lo, base60, ctrl_run;
   logic fault_q, run_q;
   logic [7:0] duty [3];
   logic [15:0] retry_ms, retry_cnt;
   logic [19:0] pump_cnt, tick_cnt, step_cnt;
   logic [1:0] probe_idx, strobe_idx;
   logic [7:0] pwm_cnt;
   logic [2:0] hi_pin, lo_pin;

   // Only the second stage is read
   wire logic fault_s = sync_b[0];
   wire logic sel_s = sync_b[1];
   wire logic mode_s = sync_b[2];
   wire logic dir_s = sync_b[3];
   wire logic start_s = sync_b[4];
   wire logic bus_s = sync_b[5];

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         // Receive line idles high; no false start bit reaches the host after reset
         sync_a <= 7'h40;
         sync_b <= 7'h40;
      end else begin
         sync_a <= {i_pwm_rate_strobe_rx, i_bus_over_threshold, i_start_input,
                    i_direction_input, i_boost_strobe_mode_select,
                    i_polarity_basefreq_select, i_fault_input};
         sync_b <= sync_a;
      end
   end

   // Reset pin pulls the whole system down
   assign o_reset_out = 1'b0;
   assign o_reset_oe = i_internal_reset_req;

   // Startup sequencer
   wire logic [19:0] step_limit = (state == ST_MODE) ? 20'(MODE_WAIT_CYCLES - 1) :
                                  (state == ST_PROBE) ? 20'(PROBE_CYCLES - 1) :
                                  20'(STROBE_CYCLES - 1);
   wire logic step_last = (step_cnt == step_limit);
   wire logic probe_hit = (state == ST_PROBE) && step_last && sel_s;
   wire logic strobe_on = standalone && (state == ST_RUN);
   wire logic host_on = !standalone && (state == ST_RUN);
   wire logic [3:0] strobe_low = strobe_on ? (4'h1 << strobe_idx) : 4'h0;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ST_MODE;
         step_cnt <= 20'h00000;
         probe_idx <= 2'h0;
         strobe_idx <= 2'h0;
         standalone <= 1'b0;
      end else begin
         step_cnt <= step_last ? 20'h00000 : step_cnt + 20'h00001;
         unique case (state)
            ST_MODE: begin
               if (step_last) begin
                  standalone <= mode_s;
                  state <= mode_s ? ST_PROBE : ST_RUN;
               end
            end
            ST_PROBE: begin
               // No jumper found: keep cycling the four pins
               if (step_last && sel_s) begin
                  state <= ST_RUN;
               end else if (step_last) begin
                  probe_idx <= probe_idx + 2'h1;
               end
            end
            ST_RUN: begin
               if (step_last) begin
                  strobe_idx <= strobe_idx + 2'h1;
               end
            end
         endcase
      end
   end

   // APB decode
   wire logic apb_wr = i_psel && i_penable && i_pwrite;
   wire logic hit_ctrl = (i_paddr == OFS_CTRL);
   wire logic hit_pol = (i_paddr == OFS_POL);
   wire logic hit_duty = (i_paddr >= OFS_DUTY_U) && (i_paddr <= OFS_DUTY_W) &&
                         (i_paddr[1:0] == 2'h0);
   wire logic [7:0] duty_ofs = i_paddr - OFS_DUTY_U;
   wire logic [1:0] duty_idx = duty_ofs[3:2];
   wire logic hit_retry = (i_paddr == OFS_RETRY);
   wire logic hit_status = (i_paddr == OFS_STATUS);
   wire logic mapped = hit_ctrl || hit_pol || hit_duty || hit_retry || hit_status;
   wire logic pol_wr = apb_wr && hit_pol && host_on && !pol_set;

   // Release edge still counts as fault; the retry count loads one edge later
   wire logic fault_any = fault_s || fault_q || (retry_cnt != 16'h0000);
   wire logic pump_active = (pump_cnt != 20'h00000);
   wire logic run_cmd = (state == ST_RUN) && pol_set && (standalone ? start_s : ctrl_run);
   wire logic enable = run_cmd && !fault_any;
   // Start edge itself belongs to the pump, before the count is loaded
   wire logic pump_on = pump_active || (run_cmd && !run_q);

   wire logic [31:0] status_word = {22'h000000, state == ST_RUN, bus_s, start_s, dir_s,
                                    enable, pump_active, retry_cnt != 16'h0000,
                                    fault_s, pol_set, standalone};
   wire logic [31:0] pol_word = {23'h000000, pol_set, 5'h00, base60, pol_lo, pol_hi};
   wire logic [31:0] rdata = hit_ctrl ? {31'h00000000, ctrl_run} :
                             hit_pol ? pol_word :
                             hit_duty ? {24'h000000, duty[duty_idx]} :
                             hit_retry ? {16'h0000, retry_ms} :
                             hit_status ? status_word : 32'h00000000;

   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_prdata <= 32'h00000000;
      end else if (i_psel && !i_penable) begin
         o_prdata <= rdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_run <= 1'b0;
         retry_ms <= RETRY_RST;
         duty[0] <= DUTY_RST;
         duty[1] <= DUTY_RST;
         duty[2] <= DUTY_RST;
      end else if (apb_wr) begin
         if (hit_ctrl) begin
            ctrl_run <= i_pwdata[CTRL_RUN_BIT] && pol_set;
         end
         if (hit_retry) begin
            retry_ms <= i_pwdata[15:0];
         end
         if (hit_duty) begin
            duty[duty_idx] <= i_pwdata[7:0];
         end
      end
   end

   // Polarity: set once by probe or host, then locked until reset
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         pol_set <= 1'b0;
         pol_hi <= 1'b0;
         pol_lo <= 1'b0;
         base60 <= 1'b0;
      end else if (probe_hit) begin
         pol_set <= 1'b1;
         pol_hi <= probe_idx[0];
         pol_lo <= probe_idx[0];
         base60 <= probe_idx[1];
      end else if (pol_wr) begin
         pol_set <= 1'b1;
         pol_hi <= i_pwdata[POL_HI_BIT];
         pol_lo <= i_pwdata[POL_LO_BIT];
         base60 <= i_pwdata[POL_60_BIT];
      end
   end

   // Pump-up on every start, retry countdown after fault release
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         run_q <= 1'b0;
         fault_q <= 1'b0;
         pump_cnt <= 20'h00000;
         retry_cnt <= 16'h0000;
         tick_cnt <= 20'h00000;
      end else begin
         run_q <= run_cmd;
         fault_q <= fault_s;
         if (run_cmd && !run_q) begin
            pump_cnt <= 20'(PUMP_CYCLES);
         end else if (pump_active) begin
            pump_cnt <= pump_cnt - 20'h00001;
         end
         if (fault_q && !fault_s) begin
            retry_cnt <= retry_ms;
            tick_cnt <= 20'h00000;
         end else if (retry_cnt != 16'h0000) begin
            // Millisecond tick from the core clock rate
            if (tick_cnt == 20'(TICK_CYCLES - 1)) begin
               tick_cnt <= 20'h00000;
               retry_cnt <= retry_cnt - 16'h0001;
            end else begin
               tick_cnt <= tick_cnt + 20'h00001;
            end
         end
      end
   end

   // PWM stage; no dead-time insertion, the gate driver must provide it
   wire logic [7:0] duty_eff [3];
   assign duty_eff[0] = duty[0];
   assign duty_eff[1] = dir_s ? duty[1] : duty[2];
   assign duty_eff[2] = dir_s ? duty[2] : duty[1];
   wire logic [2:0] next_hi;
   wire logic [2:0] next_lo;
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         wire logic cmp = (pwm_cnt < duty_eff[p]);
         wire logic hi_on = enable && !pump_on && cmp;
         wire logic lo_on = enable && (pump_on ? pwm_cnt[7] : !cmp);
         assign next_hi[p] = hi_on ~^ pol_hi;
         assign next_lo[p] = lo_on ~^ pol_lo;
      end
   endgenerate

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         pwm_cnt <= 8'h00;
         hi_pin <= 3'h0;
         lo_pin <= 3'h0;
         o_pwm_oe <= 1'b0;
      end else begin
         pwm_cnt <= pwm_cnt + 8'h01;
         hi_pin <= next_hi;
         lo_pin <= next_lo;
         o_pwm_oe <= pol_set && (state == ST_RUN);
      end
   end

   assign o_phase_u_high_drive = hi_pin[0];
   assign o_phase_v_high_drive = hi_pin[1];
   assign o_phase_w_high_drive = hi_pin[2];
   assign o_phase_u_low_drive = lo_pin[0];
   assign o_phase_v_low_drive = lo_pin[1];
   assign o_phase_w_low_drive = lo_pin[2];
   assign o_host_rxd = sync_b[6];

   // Strobe, serial, probe and brake pins
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         o_probe_out <= 4'h0;
         o_probe_oe <= 4'h0;
         o_pwm_rate_strobe_rx <= 1'b1;
         o_pwm_rate_strobe_rx_oe <= 1'b0;
         o_retry_strobe_tx <= 1'b1;
         o_deadtime_strobe_fault_out <= 1'b1;
         o_boost_strobe_mode_select <= 1'b1;
         o_boost_strobe_mode_select_oe <= 1'b0;
         o_brake_resistor_drive <= 1'b0;
      end else begin
         o_probe_out <= 4'h1 << probe_idx;
         o_probe_oe <= (state == ST_PROBE) ? 4'hf : 4'h0;
         o_pwm_rate_strobe_rx <= !strobe_low[0];
         o_pwm_rate_strobe_rx_oe <= standalone;
         o_retry_strobe_tx <= host_on ? i_host_txd : !strobe_low[1];
         o_deadtime_strobe_fault_out <= host_on ? !fault_any : !strobe_low[2];
         o_boost_strobe_mode_select <= !strobe_low[3];
         o_boost_strobe_mode_select_oe <= standalone;
         o_brake_resistor_drive <= bus_s;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   AST_HIZ_BEFORE_RUN: assert property (state != ST_RUN |=> !o_pwm_oe)
      else $error("PWM driven before run state");
   AST_FAULT_OFF: assert property (fault_s |=> hi_pin == {3{!pol_hi}} && lo_pin == {3{!pol_lo}})
      else $error("PWM not off during fault");
   AST_RETRY_HOLD: assert property ($fell(fault_s) && retry_ms != 16'h0000 |-> !enable [*4])
      else $error("PWM re-enabled during retry");
   AST_ONE_STROBE: assert property (standalone |-> $onehot0({!o_pwm_rate_strobe_rx,
      !o_retry_strobe_tx, !o_deadtime_strobe_fault_out, !o_boost_strobe_mode_select}))
      else $error("More than one strobe low");
   AST_RX_INPUT: assert property (!standalone |-> !o_pwm_rate_strobe_rx_oe)
      else $error("Receive pin driven in host mode");
   AST_TX_PASS: assert property (host_on |=> o_retry_strobe_tx == $past(i_host_txd))
      else $error("Serial transmit not passed");
   AST_FAULT_OUT: assert property (host_on && fault_s |=> !o_deadtime_strobe_fault_out)
      else $error("Fault output not low");
   AST_BRAKE: assert property (o_brake_resistor_drive == $past(bus_s))
      else $error("Brake output wrong");
   AST_PUMP_LOW_ONLY: assert property (pump_on && run_cmd |=> hi_pin == {3{!pol_hi}})
      else $error("High side on during pump-up");
   AST_POL_LOCK: assert property (pol_set |=> pol_set && $stable(pol_hi) && $stable(pol_lo))
      else $error("Polarity changed after lock");
   AST_PROBE_ONEHOT: assert property (state == ST_PROBE |=> $onehot(o_probe_out))
      else $error("Probe pins not one-hot");
   AST_MODE_ONCE: assert property (state == ST_RUN |=> $stable(standalone))
      else $error("Mode changed after selection");
endmodule
`default_nettype wire

// ---- mcps_pkg.sv ----
// Constants, offsets and types of the motor pin sequencer
package mcps_pkg;
   // Timing, counts derived from the core clock rate; MODE_WAIT_CYCLES is a fixed count
   localparam int CLK_HZ = 10_000_000;
   localparam int REF_HZ = 4_000_000;
   localparam int PUMP_MS = 100;
   localparam int PUMP_CYCLES_DEF = PUMP_MS * (CLK_HZ / 1000);
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES_DEF = TICK_MS * (CLK_HZ / 1000);
   localparam int PROBE_US = 10;
   localparam int PROBE_CYCLES = PROBE_US * (CLK_HZ / 1_000_000);
   localparam int STROBE_US = 50;
   localparam int STROBE_CYCLES = STROBE_US * (CLK_HZ / 1_000_000);
   localparam int MODE_WAIT_CYCLES = 4;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_POL = 8'h04;
   localparam logic [7:0] OFS_DUTY_U = 8'h08;
   localparam logic [7:0] OFS_DUTY_W = 8'h10;
   localparam logic [7:0] OFS_RETRY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   // Field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int POL_HI_BIT = 0;
   localparam int POL_LO_BIT = 1;
   localparam int POL_60_BIT = 2;
   localparam int POL_LOCK_BIT = 8;
   // Reset values
   localparam logic [7:0] DUTY_RST = 8'h80;
   localparam logic [15:0] RETRY_RST = 16'h0005;
   typedef enum logic [1:0] {ST_MODE, ST_PROBE, ST_RUN} mcps_state_t;
endpackage

// ---- mcps_env_model.sv ----
// Jumpers, mode strap and host serial line around the pin sequencer
`timescale 1ns/1ps
`default_nettype none
module mcps_env_model (
   // Device pin drives
   input wire logic [3:0] i_probe_out,
   input wire logic [3:0] i_probe_oe,
   input wire logic i_rate_out,
   input wire logic i_rate_oe,
   input wire logic i_boost_out,
   input wire logic i_boost_oe,
   // Board setup
   input wire logic [2:0] i_jumper,
   input wire logic i_strap_high,
   input wire logic i_host_line,
   // Pin levels seen by the device
   output logic o_select_pin,
   output logic o_rate_pin,
   output logic o_boost_pin
);
   // Index 4 or more means no jumper; select line has a pull-down
   assign o_select_pin = (i_jumper < 3'd4 && i_probe_oe[i_jumper[1:0]]) ?
      i_probe_out[i_jumper[1:0]] : 1'b0;
   // Strap resistor wins only while the device leaves the pin alone
   assign o_boost_pin = i_boost_oe ? i_boost_out : i_strap_high;
   // Idle serial line rests high
   assign o_rate_pin = i_rate_oe ? i_rate_out : i_host_line;
endmodule
`default_nettype wire

// ---- tb_motor_ctrl_pin_sequencer.sv ----
// Self-checking testbench of the motor pin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_motor_ctrl_pin_sequencer;
   import mcps_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic reset_req = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic fault = 1'b0;
   logic dir = 1'b1;
   logic start = 1'b0;
   logic bus_over = 1'b0;
   logic host_txd = 1'b1;
   logic host_line = 1'b1;
   logic strap = 1'b1;
   logic [2:0] jumper = 3'd0;
   logic reset_out, reset_oe, pready, pslverr, rate_out, rate_oe, retry_tx, dt_fault;
   logic boost_out, boost_oe, host_rxd, brake, uh, ul, vh, vl, wh, wl, pwm_oe;
   logic select_pin, rate_pin, boost_pin;
   logic [31:0] prdata;
   logic [3:0] probe_out, probe_oe;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int comparisons = 0;

   always #50 clock = ~clock;

   mcps_top #(.PUMP_CYCLES(512), .TICK_CYCLES(8)) DUT (
      .i_clock(clock), .i_resetn(resetn), .i_internal_reset_req(reset_req),
      .o_reset_out(reset_out), .o_reset_oe(reset_oe),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_polarity_basefreq_select(select_pin), .i_fault_input(fault),
      .i_direction_input(dir), .i_start_input(start), .i_bus_over_threshold(bus_over),
      .o_probe_out(probe_out), .o_probe_oe(probe_oe),
      .i_pwm_rate_strobe_rx(rate_pin), .o_pwm_rate_strobe_rx(rate_out),
      .o_pwm_rate_strobe_rx_oe(rate_oe), .o_retry_strobe_tx(retry_tx),
      .o_deadtime_strobe_fault_out(dt_fault), .i_boost_strobe_mode_select(boost_pin),
      .o_boost_strobe_mode_select(boost_out), .o_boost_strobe_mode_select_oe(boost_oe),
      .i_host_txd(host_txd), .o_host_rxd(host_rxd), .o_brake_resistor_drive(brake),
      .o_phase_u_high_drive(uh), .o_phase_u_low_drive(ul), .o_phase_v_high_drive(vh),
      .o_phase_v_low_drive(vl), .o_phase_w_high_drive(wh), .o_phase_w_low_drive(wl),
      .o_pwm_oe(pwm_oe));

   mcps_env_model ENV (
      .i_probe_out(probe_out), .i_probe_oe(probe_oe), .i_rate_out(rate_out),
      .i_rate_oe(rate_oe), .i_boost_out(boost_out), .i_boost_oe(boost_oe),
      .i_jumper(jumper), .i_strap_high(strap), .i_host_line(host_line),
      .o_select_pin(select_pin), .o_rate_pin(rate_pin), .o_boost_pin(boost_pin));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Entered just after a rising edge; waits on pready, never on a count
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so a following call never reassigns psel in this time step
      @(posedge clock);
   endtask

   task automatic do_reset(input logic s, input logic [2:0] j);
      resetn <= 1'b0;
      strap <= s;
      jumper <= j;
      @(negedge clock);
      chk({31'h0, pwm_oe}, 32'h0);
      chk({28'h0, probe_oe}, 32'h0);
      cyc(3);
      resetn <= 1'b1;
   endtask

   task automatic t_standalone(input logic [2:0] j);
      logic [31:0] exp;
      int n;
      exp = 32'h100 | (j[1] ? 32'h4 : 32'h0) | (j[0] ? 32'h3 : 32'h0);
      do_reset(1'b1, j);
      cyc(10);
      @(negedge clock);
      chk({28'h0, probe_oe}, 32'hf);
      chk({28'h0, probe_out}, 32'h1);
      @(posedge clock);
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rd[1] !== 1'b1 && n < 300);
      chk({30'h0, rd[1:0]}, 32'h3);
      // Standalone polarity comes only from the probe, so this write must not land
      apb(1'b1, OFS_POL, 32'h0);
      apb(1'b0, OFS_POL, 32'h0);
      chk(rd & 32'h107, exp);
      @(negedge clock);
      chk({28'h0, probe_oe}, 32'h0);
      @(posedge clock);
   endtask

   task automatic t_strobes();
      int lows [4];
      int multi;
      logic [3:0] s;
      multi = 0;
      lows = '{0, 0, 0, 0};
      repeat (2500) begin
         @(negedge clock);
         s = ~{boost_pin, dt_fault, retry_tx, rate_pin};
         if ((s & (s - 4'h1)) != 4'h0) multi++;
         for (int i = 0; i < 4; i++) if (s[i]) lows[i]++;
      end
      chk(multi, 0);
      chk(lows[0] + lows[1] + lows[2] + lows[3], 2500);
      chk(lows[0] >= STROBE_CYCLES, 1);
      chk(lows[1] >= STROBE_CYCLES, 1);
      chk(lows[2] >= STROBE_CYCLES, 1);
      chk(lows[3] >= STROBE_CYCLES, 1);
      @(posedge clock);
   endtask

   task automatic t_host();
      do_reset(1'b0, 3'd4);
      cyc(8);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, OFS_POL, 32'h3);
      apb(1'b1, OFS_POL, 32'h4);
      apb(1'b0, OFS_POL, 32'h0);
      chk(rd, 32'h103);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      host_line <= 1'b0;
      host_txd <= 1'b0;
      cyc(3);
      @(negedge clock);
      chk({rate_oe, host_rxd, retry_tx}, 32'h0);
      @(posedge clock);
      host_line <= 1'b1;
      host_txd <= 1'b1;
      reset_req <= 1'b1;
      cyc(3);
      @(negedge clock);
      chk({host_rxd, retry_tx}, 32'h3);
      chk({reset_oe, reset_out}, 32'h2);
      @(posedge clock);
      reset_req <= 1'b0;
   endtask

   task automatic t_drive();
      int lowcnt;
      int highs;
      lowcnt = 0;
      highs = 0;
      apb(1'b1, OFS_RETRY, 32'h2);
      apb(1'b1, OFS_CTRL, 32'h1);
      start <= 1'b1;
      dir <= 1'b0;
      bus_over <= 1'b1;
      cyc(10);
      // A 256-cycle window inside the pump spans one whole PWM period
      repeat (256) begin
         @(negedge clock);
         if (ul === 1'b1) lowcnt++;
         if ({uh, vh, wh} !== 3'b000) highs++;
      end
      chk(lowcnt, 128);
      chk(highs, 0);
      chk({pwm_oe, brake}, 32'h3);
      @(posedge clock);
      bus_over <= 1'b0;
      cyc(600);
      fault <= 1'b1;
      cyc(3);
      @(negedge clock);
      chk({uh, ul, vh, vl, wh, wl, dt_fault, brake}, 32'h0);
      @(posedge clock);
      fault <= 1'b0;
      cyc(4);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h3e8, 32'h288);
      cyc(40);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h28, 32'h20);
      chk({31'h0, dt_fault}, 32'h1);
   endtask

   task automatic tally_and_finish();
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      for (int j = 0; j < 4; j++) t_standalone(3'(j));
      t_strobes();
      t_host();
      t_drive();
      do_reset(1'b0, 3'd4);
      cyc(8);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd & 32'h22, 32'h0);
      tally_and_finish();
   end

   initial begin
      cyc(30000);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
